//--- overlay_compositor.sv
// Purpose: two scaled overlay windows composited over the main layer and background
// Assumes: raster and memory reader share CLOCK_IN; memory answers a request in the same cycle
// Notes: pixel latency two cycles; second window has priority over the first
`timescale 1ns/1ps
`default_nettype none
`include "ovl_defines.svh"
module overlay_compositor (
  input  wire logic                     CLOCK_IN,
  input  wire logic                     RESET_IN,
  input  wire logic                     HSEL_IN,
  input  wire logic [31:0]              HADDR_IN,
  input  wire logic [1:0]               HTRANS_IN,
  input  wire logic                     HWRITE_IN,
  input  wire logic [2:0]               HSIZE_IN,
  input  wire logic [31:0]              HWDATA_IN,
  input  wire logic                     HREADY_IN,
  output var  logic [31:0]              HRDATA_OUT,
  output var  logic                     HREADYOUT_OUT,
  output var  logic                     HRESP_OUT,
  input  wire logic                     RASTER_VALID_IN,
  input  wire logic [9:0]               RASTER_X_IN,
  input  wire logic [9:0]               RASTER_Y_IN,
  input  wire logic                     MAIN_VALID_IN,
  input  wire ovl_pkg::rgb_t            MAIN_PIXEL_IN,
  output logic      [1:0][19:0]         MEM_ADDR_OUT,
  output logic      [1:0]               MEM_REQ_OUT,
  input  wire logic [1:0][31:0]         MEM_DATA_IN,
  output var  logic                     PIXEL_VALID_OUT,
  output var  ovl_pkg::rgb_t            PIXEL_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  ovl_pkg::win_cfg_t cfg_q [2];
  logic [9:0]        panel_w_q;
  logic [9:0]        panel_h_q;
  ovl_pkg::rgb_t     bg_q;
  logic [31:0]       status_q;
  ovl_pkg::bus_st_t  bus_q;
  logic [31:0]       waddr_q;
  logic              acc;
  logic [19:0]       mem_addr_q [2];
  logic              req_q [2];
  logic              hit_q [2];
  logic              img_q [2];
  logic              odd_q [2];
  ovl_pkg::rgb_t     win_pix [2];
  logic              s1_valid_q;
  logic              s1_main_q;
  ovl_pkg::rgb_t     s1_mpix_q;
  logic [9:0]        s1_x_q;

  function automatic logic hit_reg(input logic [31:0] a);
    hit_reg = (a[`OVL_HI_ADDR] == '0);
  endfunction

  function automatic logic [31:0] read_reg(input logic [31:0] a);
    ovl_pkg::win_cfg_t c;
    c = cfg_q[a[`OVL_WIN_BIT]];
    read_reg = '0;
    if (!hit_reg(a)) begin
      read_reg = '0;
    end else if (a[`OVL_GLB_BIT]) begin
      case (a[`OVL_IDX])
        `OVL_G_PANEL:  read_reg = {6'h00, panel_h_q, 6'h00, panel_w_q};
        `OVL_G_BG:     read_reg = {8'h00, bg_q};
        `OVL_G_STATUS: read_reg = status_q;
        default:       read_reg = '0;
      endcase
    end else begin
      case (a[`OVL_IDX])
        `OVL_R_START: read_reg = {6'h00, c.start.y, 6'h00, c.start.x};
        `OVL_R_END:   read_reg = {6'h00, c.stop.y, 6'h00, c.stop.x};
        `OVL_R_SRC:   read_reg = {6'h00, c.src_h, 7'h00, c.src_w};
        `OVL_R_RATE:  read_reg = {3'h0, c.vrate, 3'h0, c.hrate};
        `OVL_R_ADDR:  read_reg = {12'h000, c.addr};
        `OVL_R_CTRL:  read_reg = {27'h000_0000, c.ctrl};
        `OVL_R_PANO:  read_reg = {3'h0, c.pano_vrate, 6'h00, c.pano_line};
        default:      read_reg = '0;
      endcase
    end
  endfunction

  function automatic logic [7:0] clamp8(input logic signed [19:0] v);
    if (v < 0) begin
      clamp8 = 8'h00;
    end else if (v > `OVL_PIX_MAX) begin
      clamp8 = 8'hff;
    end else begin
      clamp8 = v[7:0];
    end
  endfunction

  function automatic ovl_pkg::rgb_t yuv2rgb(input logic [7:0] y, input logic [7:0] u,
                                            input logic [7:0] v);
    logic signed [19:0] ys;
    logic signed [19:0] us;
    logic signed [19:0] vs;
    ys = $signed({12'h000, y}) <<< `OVL_K_SHIFT;
    us = $signed({12'h000, u}) - `OVL_CHROMA_OFS;
    vs = $signed({12'h000, v}) - `OVL_CHROMA_OFS;
    yuv2rgb.r = clamp8((ys + vs * `OVL_K_RV) >>> `OVL_K_SHIFT);
    yuv2rgb.g = clamp8((ys - us * `OVL_K_GU - vs * `OVL_K_GV) >>> `OVL_K_SHIFT);
    yuv2rgb.b = clamp8((ys + us * `OVL_K_BU) >>> `OVL_K_SHIFT);
  endfunction

  function automatic ovl_pkg::rgb_t widen565(input logic [15:0] p);
    widen565.r = {p[15:11], {3{p[15]}}};
    widen565.g = {p[10:5], {2{p[10]}}};
    widen565.b = {p[4:0], {3{p[4]}}};
  endfunction

  function automatic ovl_pkg::rgb_t avg(input ovl_pkg::rgb_t a, input ovl_pkg::rgb_t b);
    logic [8:0] r;
    logic [8:0] g;
    logic [8:0] bl;
    r = {1'b0, a.r} + {1'b0, b.r};
    g = {1'b0, a.g} + {1'b0, b.g};
    bl = {1'b0, a.b} + {1'b0, b.b};
    avg = {r[8:1], g[8:1], bl[8:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // zero-wait slave: read data is captured in the address phase
  assign acc = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      bus_q <= ovl_pkg::BUS_IDLE;
      waddr_q <= 32'h0000_0000;
      HRDATA_OUT <= 32'h0000_0000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      if (acc && HWRITE_IN) begin
        bus_q <= ovl_pkg::BUS_WR;
        waddr_q <= HADDR_IN;
      end else if (acc) begin
        bus_q <= ovl_pkg::BUS_RD;
        HRDATA_OUT <= read_reg(HADDR_IN);
      end else begin
        bus_q <= ovl_pkg::BUS_IDLE;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      panel_w_q <= `OVL_PANEL_W_RST;
      panel_h_q <= `OVL_PANEL_H_RST;
      bg_q <= 24'h00_0000;
    end else if (bus_q == ovl_pkg::BUS_WR && hit_reg(waddr_q) && waddr_q[`OVL_GLB_BIT]) begin
      case (waddr_q[`OVL_IDX])
        `OVL_G_PANEL: begin
          panel_w_q <= HWDATA_IN[`OVL_F_LO10];
          panel_h_q <= HWDATA_IN[`OVL_F_HI10];
        end
        `OVL_G_BG: bg_q <= HWDATA_IN[`OVL_F_RGB];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      status_q <= 32'h0000_0000;
    end else if (s1_valid_q) begin
      status_q <= {28'h000_0000, img_q[1], img_q[0], hit_q[1], hit_q[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two independent windows
  for (genvar w = 0; w < 2; w++) begin : g_win
    logic               sel;
    logic               covered;
    logic               in_img;
    logic [9:0]         dx;
    logic [9:0]         dy;
    logic [22:0]        sxp;
    logic [23:0]        syp;
    logic [12:0]        sx;
    logic [13:0]        sy;
    logic [19:0]        pix;
    logic [19:0]        byte_addr;
    ovl_pkg::rgb_t      conv;
    ovl_pkg::rgb_t      hf;
    ovl_pkg::rgb_t      vf;
    ovl_pkg::rgb_t      hprev_q;
    ovl_pkg::rgb_t      line_mem [1024];
    logic [31:0]        word;
    logic [15:0]        half;

    assign sel = hit_reg(waddr_q) && !waddr_q[`OVL_GLB_BIT] && (waddr_q[`OVL_WIN_BIT] == w);

    always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
        cfg_q[w] <= '0;
        cfg_q[w].hrate <= `OVL_RATE_UNITY;
        cfg_q[w].vrate <= `OVL_RATE_UNITY;
        cfg_q[w].pano_vrate <= `OVL_RATE_UNITY;
      end else if (bus_q == ovl_pkg::BUS_WR && sel) begin
        case (waddr_q[`OVL_IDX])
          `OVL_R_START: cfg_q[w].start <= {HWDATA_IN[`OVL_F_LO10], HWDATA_IN[`OVL_F_HI10]};
          `OVL_R_END:   cfg_q[w].stop <= {HWDATA_IN[`OVL_F_LO10], HWDATA_IN[`OVL_F_HI10]};
          `OVL_R_SRC: begin
            cfg_q[w].src_w <= HWDATA_IN[`OVL_F_W];
            cfg_q[w].src_h <= HWDATA_IN[`OVL_F_HI10];
          end
          `OVL_R_RATE: begin
            cfg_q[w].hrate <= HWDATA_IN[`OVL_F_HR];
            cfg_q[w].vrate <= HWDATA_IN[`OVL_F_VR];
          end
          `OVL_R_ADDR:  cfg_q[w].addr <= HWDATA_IN[`OVL_F_ADDR];
          `OVL_R_CTRL:  cfg_q[w].ctrl <= HWDATA_IN[`OVL_F_CTRL];
          `OVL_R_PANO: begin
            cfg_q[w].pano_line <= HWDATA_IN[`OVL_F_LO10];
            cfg_q[w].pano_vrate <= HWDATA_IN[`OVL_F_VR];
          end
          default: ;
        endcase
      end
    end

    always_comb begin
      dx = RASTER_X_IN - cfg_q[w].start.x;
      dy = RASTER_Y_IN - cfg_q[w].start.y;
      // window span from start to end
      covered = cfg_q[w].ctrl.en && RASTER_X_IN >= cfg_q[w].start.x
                && RASTER_X_IN < cfg_q[w].stop.x && RASTER_Y_IN >= cfg_q[w].start.y
                && RASTER_Y_IN < cfg_q[w].stop.y;
      // 13-bit rate, source step is rate over 1024
      sxp = 23'(dx) * 23'(cfg_q[w].hrate);
      if (w == 1 && cfg_q[w].ctrl.pano && dy >= cfg_q[w].pano_line) begin
        syp = 24'(cfg_q[w].pano_line) * 24'(cfg_q[w].vrate)
              + 24'(dy - cfg_q[w].pano_line) * 24'(cfg_q[w].pano_vrate);
      end else begin
        syp = 24'(dy) * 24'(cfg_q[w].vrate);
      end
      sx = sxp[22:`OVL_RATE_SHIFT];
      sy = syp[23:`OVL_RATE_SHIFT];
      // inside scaled image when source index in range
      in_img = (sx < 13'(cfg_q[w].src_w)) && (sy < 14'(cfg_q[w].src_h));
      pix = 20'(sy) * 20'(cfg_q[w].src_w) + 20'(sx);
      byte_addr = cfg_q[w].addr + {pix[18:1], 2'b00};
    end

    always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
        mem_addr_q[w] <= 20'h0_0000;
        req_q[w] <= 1'b0;
        hit_q[w] <= 1'b0;
        img_q[w] <= 1'b0;
        odd_q[w] <= 1'b0;
      end else begin
        req_q[w] <= RASTER_VALID_IN && covered && in_img;
        hit_q[w] <= RASTER_VALID_IN && covered;
        img_q[w] <= in_img;
        odd_q[w] <= pix[0];
        if (RASTER_VALID_IN && covered && in_img) begin
          mem_addr_q[w] <= byte_addr;
        end
      end
    end

    assign MEM_ADDR_OUT[w] = mem_addr_q[w];
    assign MEM_REQ_OUT[w] = req_q[w];

    always_comb begin
      word = MEM_DATA_IN[w];
      half = odd_q[w] ? word[31:16] : word[15:0];
      if (cfg_q[w].ctrl.yuv) begin
        conv = yuv2rgb(half[15:8], word[7:0], word[23:16]);
      end else begin
        conv = widen565(half);
      end
      hf = cfg_q[w].ctrl.hfilt ? avg(conv, hprev_q) : conv;
      vf = cfg_q[w].ctrl.vfilt ? avg(hf, line_mem[s1_x_q]) : hf;
      win_pix[w] = img_q[w] ? vf : 24'h00_0000;
    end

    // last fetched pixel feeds the horizontal filter, line store keeps the previous row for the vertical filter
    always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
        hprev_q <= 24'h00_0000;
      end else if (s1_valid_q && hit_q[w] && img_q[w]) begin
        hprev_q <= conv;
      end
    end

    always_ff @(posedge CLOCK_IN) begin
      if (s1_valid_q && hit_q[w] && img_q[w]) begin
        line_mem[s1_x_q] <= hf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      s1_valid_q <= 1'b0;
      s1_main_q <= 1'b0;
      s1_mpix_q <= 24'h00_0000;
      s1_x_q <= 10'h000;
    end else begin
      s1_valid_q <= RASTER_VALID_IN;
      s1_main_q <= MAIN_VALID_IN;
      s1_mpix_q <= MAIN_PIXEL_IN;
      s1_x_q <= RASTER_X_IN;
    end
  end

  // second window on top so an overlap shows it whole
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      PIXEL_VALID_OUT <= 1'b0;
      PIXEL_OUT <= 24'h00_0000;
    end else begin
      PIXEL_VALID_OUT <= s1_valid_q;
      if (hit_q[1]) begin
        PIXEL_OUT <= win_pix[1];
      end else if (hit_q[0]) begin
        PIXEL_OUT <= win_pix[0];
      end else if (s1_main_q) begin
        PIXEL_OUT <= s1_mpix_q;
      end else begin
        PIXEL_OUT <= bg_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_bus_write;
    acc && HWRITE_IN && HADDR_IN == `OVL_BG_ADDR;
  endsequence

  chk_bus_okay: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    HREADYOUT_OUT && !HRESP_OUT) else $error("slave not ready or error");
  chk_bg_write: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    s_bus_write ##1 1'b1 |=> bg_q == $past(HWDATA_IN[`OVL_F_RGB]))
    else $error("background write lost");
  chk_pix_latency: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    RASTER_VALID_IN |-> ##2 PIXEL_VALID_OUT) else $error("pixel latency wrong");
  chk_bg_fill: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    RASTER_VALID_IN && !MAIN_VALID_IN && !g_win[0].covered && !g_win[1].covered
    ##1 $stable(bg_q) |=> PIXEL_OUT == $past(bg_q)) else $error("background not shown");
  chk_black_pad: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    hit_q[1] && !img_q[1] |=> PIXEL_OUT == 24'h00_0000) else $error("pad not black");
  chk_trim_edge: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    !g_win[0].covered |=> !MEM_REQ_OUT[0]) else $error("fetch outside window");
  chk_origin_addr: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    RASTER_VALID_IN && cfg_q[0].ctrl.en && RASTER_X_IN == cfg_q[0].start.x
    && RASTER_Y_IN == cfg_q[0].start.y && g_win[0].covered && g_win[0].in_img
    |=> MEM_ADDR_OUT[0] == $past(cfg_q[0].addr)) else $error("origin not at start");
  chk_rgb_widen: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    hit_q[1] && img_q[1] && !cfg_q[1].ctrl.yuv && cfg_q[1].ctrl == $past(cfg_q[1].ctrl)
    && !cfg_q[1].ctrl.hfilt && !cfg_q[1].ctrl.vfilt
    |=> PIXEL_OUT.r[2:0] == {3{PIXEL_OUT.r[7]}}) else $error("red not widened");
  chk_unity_step: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
    cfg_q[0].hrate == `OVL_RATE_UNITY |-> g_win[0].sx == 13'(g_win[0].dx))
    else $error("unity rate not one to one");
endmodule // overlay_compositor
`default_nettype wire

//--- ovl_defines.svh
// Purpose: offsets, fields, reset values and coefficients of the overlay compositor
// Assumes: 32-bit AHB-Lite register words, 100 MHz CLOCK_IN
// Notes: every register offset, write field and YUV coefficient that the logic uses is named here
// Operation
// - two independent overlay windows, free to overlap each other and main layer
// - each window placed by start and end x,y from panel top-left 0,0
// - pixels covered by no window and no main layer show background colour
// - source pixels fetched from start address as RGB 5:6:5 or YUV 4:2:2
// - scaler enlarges up to 8x, reduces to 1/8x; software never requests less
// - separately enabled horizontal and vertical filters smooth scaled images
// - second window also scales vertically at a second rate below a line
// - scaled image smaller than window sits at origin, rest shows black
// - scaled image equal to window span fills the window from its origin
// - scaled image larger than window is trimmed at the window edges
// - horizontal rate is 1024 over the ratio; above 1024 reduces
// - vertical rate is 1024 over the ratio, same sense as horizontal
// - every overlay pixel leaves as 24-bit RGB 8:8:8
// - 5:6:5 components widen with original bits high, msb repeated below
// - YUV converts as R=Y+1.402V, G=Y-0.344U-0.714V, B=Y+1.722U
`ifndef OVL_DEFINES_SVH
`define OVL_DEFINES_SVH
`define OVL_WIN_BIT     5
`define OVL_GLB_BIT     6
`define OVL_HI_ADDR     31:7
`define OVL_IDX         4:2
`define OVL_R_START     3'h0
`define OVL_R_END       3'h1
`define OVL_R_SRC       3'h2
`define OVL_R_RATE      3'h3
`define OVL_R_ADDR      3'h4
`define OVL_R_CTRL      3'h5
`define OVL_R_PANO      3'h6
`define OVL_G_PANEL     3'h0
`define OVL_G_BG        3'h1
`define OVL_G_STATUS    3'h2
`define OVL_BG_ADDR     32'h0000_0044
`define OVL_F_LO10      9:0
`define OVL_F_HI10      25:16
`define OVL_F_W         8:0
`define OVL_F_HR        12:0
`define OVL_F_VR        28:16
`define OVL_F_ADDR      19:0
`define OVL_F_CTRL      4:0
`define OVL_F_RGB       23:0
`define OVL_RATE_UNITY  13'h0400
`define OVL_RATE_SHIFT  10
`define OVL_PANEL_W_RST 10'h1e0
`define OVL_PANEL_H_RST 10'h320
`define OVL_K_RV        20'sh0_0167
`define OVL_K_GU        20'sh0_0058
`define OVL_K_GV        20'sh0_00b7
`define OVL_K_BU        20'sh0_01b9
`define OVL_K_SHIFT     8
`define OVL_CHROMA_OFS  20'sh0_0080
`define OVL_PIX_MAX     20'sh0_00ff
`endif

//--- ovl_pkg.sv
// Purpose: types shared by the overlay compositor
// Assumes: nothing beyond SystemVerilog packed structs and enums
// Notes: window configuration travels as one struct
package ovl_pkg;
  typedef struct packed {
    logic [9:0] x;
    logic [9:0] y;
  } xy_t;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;
  typedef struct packed {
    logic pano;
    logic vfilt;
    logic hfilt;
    logic yuv;
    logic en;
  } ctrl_t;
  typedef struct packed {
    xy_t         start;
    xy_t         stop;
    logic [8:0]  src_w;
    logic [9:0]  src_h;
    logic [12:0] hrate;
    logic [12:0] vrate;
    logic [19:0] addr;
    ctrl_t       ctrl;
    logic [9:0]  pano_line;
    logic [12:0] pano_vrate;
  } win_cfg_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } bus_st_t;
endpackage

//--- ovl_mem_model.sv
// Purpose: display memory reader partner for the overlay compositor
// Assumes: a fetch is answered combinationally in the cycle of its request
// Notes: contents are a fixed hash of the word address, shared with the bench
`timescale 1ns/1ps
`default_nettype none
module ovl_mem_model (
  input  wire logic                  clk_in,
  input  wire logic [1:0]            req_in,
  input  wire logic [1:0][19:0]      addr_in,
  output logic      [1:0][31:0]      data_out
);
  logic [1:0][31:0] last_q = '0;

  function automatic logic [31:0] word_at(input logic [19:0] a);
    return ({12'h000, a} * 32'h9e37_79b1) ^ 32'h5a5a_c3c3;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // a released data bus shows the inverse of its last word, not a stale copy
  always @(posedge clk_in) begin
    for (int w = 0; w < 2; w++) begin
      if (req_in[w]) begin
        last_q[w] <= data_out[w];
      end
    end
  end

  always_comb begin
    for (int w = 0; w < 2; w++) begin
      data_out[w] = req_in[w] ? word_at(addr_in[w]) : ~last_q[w];
    end
  end
endmodule // ovl_mem_model
`default_nettype wire

//--- test_overlay_compositor.sv
// Purpose: self-checking bench for the overlay compositor
// Assumes: zero-wait bus slave, pixel answer two cycles after the raster pixel
// Notes: filters are modelled as two-tap averages, panorama as a second vertical rate
`timescale 1ns/1ps
`default_nettype none
module test_overlay_compositor;
  logic             clk    = 1'b0;
  logic             rst    = 1'b1;
  logic             hsel   = 1'b0;
  logic [31:0]      haddr  = 32'h0000_0000;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0000_0000;
  logic             rv     = 1'b0;
  logic [9:0]       rx     = 10'h000;
  logic [9:0]       ry     = 10'h000;
  logic             mv     = 1'b0;
  ovl_pkg::rgb_t    mp     = '0;
  logic [31:0]      hrdata;
  logic             hready;
  logic             hresp;
  logic [1:0][19:0] maddr;
  logic [1:0]       mreq;
  logic [1:0][31:0] mdata;
  logic             pv;
  ovl_pkg::rgb_t    px;
  int               miscompares = 0;
  int               comparisons = 0;
  int               xs[2], ys[2], xe[2], ye[2], sw[2], sh[2], hr[2], vr[2], ad[2];
  int               yuv[2], en[2], hf[2], vf[2], pn[2], pl[2], pr[2], bg;
  logic [23:0]      e_pix;
  logic [1:0]       e_req;
  logic [19:0]      e_adr[2];
  logic [23:0]      hp[2] = '{default: 24'h00_0000};
  logic [23:0]      ln[2][1024];

  initial begin
    forever #5 clk = ~clk;
  end

  overlay_compositor DUT (.CLOCK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .RASTER_VALID_IN(rv), .RASTER_X_IN(rx), .RASTER_Y_IN(ry), .MAIN_VALID_IN(mv),
    .MAIN_PIXEL_IN(mp), .MEM_ADDR_OUT(maddr), .MEM_REQ_OUT(mreq), .MEM_DATA_IN(mdata),
    .PIXEL_VALID_OUT(pv), .PIXEL_OUT(px));

  ovl_mem_model mem (.clk_in(clk), .req_in(mreq), .addr_in(maddr), .data_out(mdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    r = hrdata;
    check({31'h0, hresp}, 32'h0000_0000);
    if (n >= 64) begin
      miscompares++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check(r, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // software side keeps windows inside the panel, sources 4x4..510x1022, rates >= 1/8
  // configuration limits
  task automatic set_win(input int w, a, b, c, d, e, f, g, h, k, m);
    xs[w] = a; ys[w] = b; xe[w] = c; ye[w] = d; sw[w] = e; sh[w] = f;
    hr[w] = g; vr[w] = h; ad[w] = k; en[w] = m & 1; yuv[w] = (m >> 1) & 1;
    hf[w] = (m >> 2) & 1;
    vf[w] = (m >> 3) & 1;
    pn[w] = (m >> 4) & 1;
    wr(32'(32 * w), 32'((b << 16) | a));
    wr(32'(32 * w + 4), 32'((d << 16) | c));
    wr(32'(32 * w + 8), 32'((f << 16) | e));
    wr(32'(32 * w + 12), 32'((h << 16) | g));
    wr(32'(32 * w + 16), 32'(k));
    wr(32'(32 * w + 20), 32'(m));
  endtask

  function automatic logic [31:0] word_at(input logic [19:0] a);
    return ({12'h000, a} * 32'h9e37_79b1) ^ 32'h5a5a_c3c3;
  endfunction

  function automatic logic [7:0] clip(input int v);
    return (v < 0) ? 8'h00 : ((v > 255) ? 8'hff : 8'(v));
  endfunction

  function automatic logic [23:0] conv(input int w, input logic [31:0] wd, input int odd);
    logic [15:0] hw;
    int          yv, u, v;
    hw = odd ? wd[31:16] : wd[15:0];
    if (yuv[w] == 0) return {hw[15:11], {3{hw[15]}}, hw[10:5], {2{hw[10]}}, hw[4:0], {3{hw[4]}}};
    yv = int'(hw[15:8]);
    u  = int'(wd[7:0]) - 128;
    v  = int'(wd[23:16]) - 128;
    return {clip((256 * yv + 359 * v) >>> 8), clip((256 * yv - 88 * u - 183 * v) >>> 8),
            clip((256 * yv + 441 * u) >>> 8)};
  endfunction

  function automatic logic [23:0] avg(input logic [23:0] a, b);
    logic [23:0] r;
    for (int i = 0; i < 24; i += 8) begin
      r[i +: 8] = 8'((int'(a[i +: 8]) + int'(b[i +: 8])) >> 1);
    end
    return r;
  endfunction

  task automatic model(input int x, y, input logic m, input logic [23:0] p);
    int          sx, sy, idx;
    logic [23:0] c, h;
    e_pix = m ? p : 24'(bg);
    e_req = 2'b00;
    for (int w = 0; w < 2; w++) begin
      if (en[w] == 1 && x >= xs[w] && x < xe[w] && y >= ys[w] && y < ye[w]) begin
        sx = ((x - xs[w]) * hr[w]) >> 10;
        sy = ((y - ys[w]) * vr[w]) >> 10;
        // second vertical rate from the split line down
        if (w == 1 && pn[w] == 1 && y - ys[w] >= pl[w]) begin
          sy = (pl[w] * vr[w] + (y - ys[w] - pl[w]) * pr[w]) >> 10;
        end
        e_pix = 24'h00_0000;
        if (sx < sw[w] && sy < sh[w]) begin
          idx = sy * sw[w] + sx;
          e_adr[w] = 20'(ad[w] + 2 * (idx & ~1));
          e_req[w] = 1'b1;
          c = conv(w, word_at(e_adr[w]), idx & 1);
          // smoothing against last fetch and same column of last row
          h = hf[w] ? avg(c, hp[w]) : c;
          e_pix = vf[w] ? avg(h, ln[w][x]) : h;
          hp[w] = c;
          ln[w][x] = h;
        end
      end
    end
  endtask

  task automatic send(input int x, y);
    logic        m;
    logic [23:0] p;
    m = 1'($urandom);
    p = 24'($urandom);
    model(x, y, m, p);
    @(posedge clk);
    rv <= 1'b1; rx <= 10'(x); ry <= 10'(y); mv <= m; mp <= p;
    @(posedge clk);
    rv <= 1'b0;
    #1;
    for (int w = 0; w < 2; w++) begin
      check({31'h0, mreq[w]}, {31'h0, e_req[w]});
      if (e_req[w]) check({12'h000, maddr[w]}, {12'h000, e_adr[w]});
    end
    @(posedge clk);
    #1;
    check({31'h0, pv}, 32'h0000_0001);
    check({8'h00, px}, {8'h00, e_pix});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(69));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(32'h0000_000c, 32'h0400_0400);
    rd(32'h0000_0040, 32'h0320_01e0);
    wr(32'h0000_0080, 32'hffff_ffff);
    rd(32'h0000_0080, 32'h0000_0000);
    rd(32'h0000_001c, 32'h0000_0000);
    bg = int'($urandom) & 32'h00ff_ffff;
    wr(32'h0000_0044, 32'(bg));
    rd(32'h0000_0044, 32'(bg));
    // unity fill, black padding, 2x trim under a reduced yuv window, 1.5x and 0.7x, filters
    for (int c = 0; c < 5; c++) begin
      case (c)
        0: begin
          set_win(0, 16, 8, 24, 16, 8, 8, 1024, 1024, 256, 1);
          set_win(1, 0, 0, 0, 0, 4, 4, 1024, 1024, 0, 0);
        end
        1: set_win(0, 16, 8, 28, 20, 8, 8, 1024, 1024, 256, 1);
        2: begin
          set_win(0, 16, 8, 24, 16, 8, 8, 512, 512, 256, 1);
          set_win(1, 20, 12, 30, 20, 6, 6, 2048, 2048, 4096, 3);
        end
        3: begin
          set_win(0, 0, 0, 0, 0, 4, 4, 1024, 1024, 0, 0);
          set_win(1, 16, 8, 26, 20, 8, 10, 682, 1462, 512, 1);
        end
        // both filters and a panorama split on the second window
        default: begin
          pl[1] = 4;
          pr[1] = 2048;
          wr(32'h0000_0038, 32'h0800_0004);
          set_win(1, 16, 8, 26, 20, 8, 10, 1024, 512, 512, 29);
        end
      endcase
      for (int y = 6; y < 22; y++) begin
        for (int x = 14; x < 32; x++) begin
          send(x, y);
        end
      end
    end
    repeat (16) send(int'($urandom % 480), int'($urandom % 800));
    print_verdict();
  end
endmodule // test_overlay_compositor
`default_nettype wire
